// ### hdl/flash_config_registers.v
// function register and read-parameter register pair of a serial flash
// assumes serial pins asynchronous to clock; program/erase engine on clock
`timescale 1ns/10ps
`include "flash_cfg_consts.vh"
module flash_config_registers #(
    parameter       HAS_DEDICATED_RESET = 1,
    parameter [0:0] RESET_DIS_DEFAULT   = 1'b0
) (
    // clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // serial link pins
    input  wire       sck,
    input  wire       csN,
    input  wire       si,
    output reg        so,
    output reg        soOe,
    // reset and shared pins
    input  wire       dedicatedResetPinN,
    input  wire       sharedPinN,
    // mode levels from the status logic
    input  wire       quadEnable,
    input  wire       fourWireCmdMode,
    // suspend and resume events from the program/erase engine
    input  wire       programActive,
    input  wire       eraseActive,
    input  wire       suspendAccepted,
    input  wire       programResumed,
    input  wire       eraseResumed,
    // information row program request
    input  wire       rowProgReq,
    input  wire [1:0] rowSel,
    output reg        rowProgGrant,
    output reg        rowProgReject,
    // resolved configuration
    output reg  [1:0] sharedPinFunction,
    output reg        holdActive,
    output reg        deviceResetReq,
    output reg        protectAreaBottom,
    output reg  [3:0] readDummyCycles,
    output reg        wrapEnable,
    output reg        wrapWholeArray,
    output reg  [6:0] wrapBytes,
    output reg  [7:0] functionValue,
    output reg  [7:0] readParamsVolatile
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_WDATA = 2'h1;
    localparam [1:0] ST_READ  = 2'h2;
    localparam [1:0] ST_DONE  = 2'h3;

    localparam HAS_DED = (HAS_DEDICATED_RESET != 0);
    // reset word of the function register; bit 0 depends on the package variant
    localparam [7:0] FN_RESET_WORD = (`FN_RESET_VALUE & 8'hfe) | {7'h00, RESET_DIS_DEFAULT};

    // synchronisers: stage 1 read only by stage 2
    reg [4:0] pinMeta_r;
    reg [4:0] pinSync_r;
    reg       sckPrev_r;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] opcode_r;
    reg [7:0] opcode_nxt;
    reg       loadByte_nxt;
    reg [7:0] txByte_nxt;

    reg [7:0] fnReg_r;
    reg [7:0] rpNv_r;
    reg [7:0] rpVol_r;
    reg       powerLoad_r;

    // next values of the register bank
    reg [7:0] fnReg_nxt;
    reg [7:0] rpNv_nxt;
    reg [7:0] rpVol_nxt;

    // next values of the registered outputs
    reg [1:0] pinFn_nxt;
    reg       rowLocked;
    reg       rowProgGrant_nxt;
    reg       rowProgReject_nxt;
    reg       holdActive_nxt;
    reg       deviceResetReq_nxt;
    reg [3:0] readDummyCycles_nxt;
    reg [6:0] wrapBytes_nxt;
    reg       soOe_nxt;

    wire       sckS  = pinSync_r[0];
    wire       csS_n = pinSync_r[1];
    wire       siS   = pinSync_r[2];
    wire       dedRstS_n = pinSync_r[3];
    wire       shrS_n    = pinSync_r[4];
    wire       sckRise = sckS & ~sckPrev_r;
    wire       sckFall = ~sckS & sckPrev_r;
    wire       csActive = ~csS_n;
    wire [7:0] rxByte;
    wire       rxValid;
    wire       soBit;

    wire       resetDisabled = fnReg_r[`FN_RESET_DIS_BIT];
    wire       wrFunction = (state_r == ST_WDATA) && rxValid && (opcode_r == `OP_SET_FUNCTION);
    wire       wrNv = (state_r == ST_WDATA) && rxValid && (opcode_r == `OP_SET_READ_NV);
    wire       wrVol = (state_r == ST_WDATA) && rxValid &&
                       (opcode_r == `OP_SET_READ_V0 || opcode_r == `OP_SET_READ_V1);

    // dummy field decode shared by both modes
    function [3:0] dummyCount;
        input [7:0] rp;
        input       four_wire_command_mode;
        begin
            if (rp[`RP_DUMMY_MSB:`RP_DUMMY_LSB] == 4'h0)
                dummyCount = four_wire_command_mode ? `DUMMY_DEF_QPI : `DUMMY_DEF_SPI;
            else
                dummyCount = rp[`RP_DUMMY_MSB:`RP_DUMMY_LSB];
        end
    endfunction

    function [6:0] wrapLength;
        input [1:0] code;
        begin
            case (code)
                2'h0:    wrapLength = `WRAP_LEN_8;
                2'h1:    wrapLength = `WRAP_LEN_16;
                2'h2:    wrapLength = `WRAP_LEN_32;
                default: wrapLength = `WRAP_LEN_64;
            endcase
        end
    endfunction

    function [1:0] pinFunction;
        input       qe;
        input       four_wire_command_mode;
        input       resetDis;
        input       pinSel;
        begin
            if (qe || four_wire_command_mode)
                pinFunction = `PIN_FN_DATA3;
            else if (HAS_DED && !resetDis)
                pinFunction = `PIN_FN_HOLD;
            else if (HAS_DED)
                pinFunction = `PIN_FN_RESET;
            else
                pinFunction = pinSel ? `PIN_FN_RESET : `PIN_FN_HOLD;
        end
    endfunction

    always @(posedge clock) begin
        if (!rst_n) begin
            pinMeta_r <= 5'h1a;
            pinSync_r <= 5'h1a;
            sckPrev_r <= 1'b0;
        end else begin
            pinMeta_r <= {sharedPinN, dedicatedResetPinN, si, csN, sck};
            pinSync_r <= pinMeta_r;
            sckPrev_r <= sckS;
        end
    end

    serial_byte_shifter shifter (
        .clock    (clock),
        .rst_n    (rst_n),
        .sckRise  (sckRise),
        .sckFall  (sckFall),
        .csActive (csActive),
        .siBit    (siS),
        .loadByte (loadByte_nxt),
        .txByte   (txByte_nxt),
        .rxByte   (rxByte),
        .rxValid  (rxValid),
        .soBit    (soBit)
    );

    // command sequencer: opcode byte, then one data byte in, or data bytes out for as long as the host clocks
    always @* begin
        state_nxt    = state_r;
        opcode_nxt   = opcode_r;
        loadByte_nxt = 1'b0;
        txByte_nxt   = 8'h00;
        case (state_r)
            ST_IDLE: begin
                if (rxValid) begin
                    opcode_nxt = rxByte;
                    case (rxByte)
                        `OP_SET_READ_NV, `OP_SET_READ_V0, `OP_SET_READ_V1,
                        `OP_SET_FUNCTION: begin
                            state_nxt = ST_WDATA;
                        end
                        `OP_GET_READ_PARAMS: begin
                            state_nxt    = ST_READ;
                            loadByte_nxt = 1'b1;
                            txByte_nxt   = rpVol_r;
                        end
                        `OP_GET_FUNCTION: begin
                            state_nxt    = ST_READ;
                            loadByte_nxt = 1'b1;
                            txByte_nxt   = fnReg_r;
                        end
                        default: begin
                            state_nxt = ST_DONE;
                        end
                    endcase
                end
            end
            ST_WDATA: begin
                if (rxValid)
                    state_nxt = ST_DONE;
            end
            ST_READ: begin
                // reads repeat the same register for as long as the host clocks
                if (rxValid) begin
                    loadByte_nxt = 1'b1;
                    txByte_nxt   = (opcode_r == `OP_GET_FUNCTION) ? fnReg_r : rpVol_r;
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!csActive)
            state_nxt = ST_IDLE;
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            state_r  <= ST_IDLE;
            opcode_r <= 8'h00;
        end else begin
            state_r  <= state_nxt;
            opcode_r <= opcode_nxt;
        end
    end

    // function register: host data reaches only the one-time bits and can only set them
    always @* begin
        fnReg_nxt = fnReg_r;
        if (wrFunction) begin
            fnReg_nxt[7:4] = fnReg_r[7:4] | rxByte[7:4];
            fnReg_nxt[1]   = fnReg_r[1] | rxByte[1];
            fnReg_nxt[0]   = fnReg_r[0] | rxByte[0];
            // suspend flags stay out of the write, they follow the engine only
            fnReg_nxt[3:2] = fnReg_r[3:2];
        end
        // a suspend meeting a resume in the same cycle wins
        if (suspendAccepted && programActive)
            fnReg_nxt[`FN_PROGRAM_SUSPENDED_FLAG_BIT] = 1'b1;
        else if (programResumed)
            fnReg_nxt[`FN_PROGRAM_SUSPENDED_FLAG_BIT] = 1'b0;
        if (suspendAccepted && eraseActive)
            fnReg_nxt[`FN_ERASE_SUSPENDED_FLAG_BIT] = 1'b1;
        else if (eraseResumed)
            fnReg_nxt[`FN_ERASE_SUSPENDED_FLAG_BIT] = 1'b0;
    end

    always @(posedge clock) begin
        if (!rst_n)
            fnReg_r <= FN_RESET_WORD;
        else
            fnReg_r <= fnReg_nxt;
    end

    // read parameter pair; reset stands for power-up, so the copy follows release
    always @* begin
        rpNv_nxt  = rpNv_r;
        rpVol_nxt = rpVol_r;
        // a non-volatile write leaves the working copy alone until power-up
        if (wrNv)
            rpNv_nxt = rxByte;
        // the power-up load takes precedence over a volatile write
        if (powerLoad_r)
            rpVol_nxt = rpNv_r;
        else if (wrVol)
            rpVol_nxt = rxByte;
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            rpNv_r      <= `RP_RESET_VALUE;
            rpVol_r     <= `RP_RESET_VALUE;
            powerLoad_r <= 1'b1;
        end else begin
            powerLoad_r <= 1'b0;
            rpNv_r      <= rpNv_nxt;
            rpVol_r     <= rpVol_nxt;
        end
    end

    // next values; one pin decode feeds three outputs
    always @* begin
        pinFn_nxt           = pinFunction(quadEnable, fourWireCmdMode, resetDisabled,
                                          rpVol_r[`RP_PIN_SEL_BIT]);
        // judged on the live register so a new lock holds with no extra cycle
        rowLocked           = fnReg_r[`FN_ROWLOCK_LSB + rowSel];
        rowProgGrant_nxt    = rowProgReq && !rowLocked;
        rowProgReject_nxt   = rowProgReq && rowLocked;
        holdActive_nxt      = (pinFn_nxt == `PIN_FN_HOLD) && !shrS_n;
        // dedicated pin is ignored once disabled
        deviceResetReq_nxt  = (HAS_DED && !resetDisabled && !dedRstS_n) ||
                              ((pinFn_nxt == `PIN_FN_RESET) && !shrS_n);
        // a zero dummy field falls back to the command default
        readDummyCycles_nxt = dummyCount(rpVol_r, fourWireCmdMode);
        wrapBytes_nxt       = wrapLength(rpVol_r[`RP_LEN_MSB:`RP_LEN_LSB]);
        // so is driven only once a read opcode has been taken
        soOe_nxt            = csActive && (state_r == ST_READ);
    end

    // resolved outputs, all registered
    always @(posedge clock) begin
        if (!rst_n) begin
            so                 <= 1'b0;
            soOe               <= 1'b0;
            rowProgGrant       <= 1'b0;
            rowProgReject      <= 1'b0;
            sharedPinFunction  <= `PIN_FN_HOLD;
            holdActive         <= 1'b0;
            deviceResetReq     <= 1'b0;
            protectAreaBottom  <= 1'b0;
            readDummyCycles    <= `DUMMY_DEF_SPI;
            wrapEnable         <= 1'b0;
            wrapWholeArray     <= 1'b1;
            wrapBytes          <= `WRAP_LEN_8;
            functionValue      <= FN_RESET_WORD;
            readParamsVolatile <= `RP_RESET_VALUE;
        end else begin
            so                 <= soBit;
            soOe               <= soOe_nxt;
            rowProgGrant       <= rowProgGrant_nxt;
            rowProgReject      <= rowProgReject_nxt;
            sharedPinFunction  <= pinFn_nxt;
            holdActive         <= holdActive_nxt;
            deviceResetReq     <= deviceResetReq_nxt;
            protectAreaBottom  <= fnReg_r[`FN_BOTTOM_BIT];
            readDummyCycles    <= readDummyCycles_nxt;
            wrapEnable         <= rpVol_r[`RP_WRAP_EN_BIT];
            wrapWholeArray     <= !rpVol_r[`RP_WRAP_EN_BIT];
            wrapBytes          <= wrapBytes_nxt;
            functionValue      <= fnReg_r;
            readParamsVolatile <= rpVol_r;
        end
    end
endmodule

// ### hdl/flash_cfg_consts.vh
// constants for the flash function and read-parameter register logic
// assumes one 50 MHz system clock that samples every serial pin
//
// Contract
// - function bit 0 shows dedicated reset pin disabled; writable only while 0
// - reset-disable bit resets per package variant, other function bits reset to 0
// - reset-disable set on dedicated-pin part moves reset onto the shared pin
// - function bit 1 selects top (0) or bottom (1) protect area
// - one-time bits once 1 stay 1; writing 0 has no effect
// - bit 2 set by suspend during program, cleared on program resume
// - bit 3 set by suspend during erase, cleared on erase resume
// - bits 4..7 lock information rows 0..3 against programming
// - power-up loads volatile read parameters from the non-volatile copy
// - read bit 7 picks hold (0) or reset (1) for shared pin
// - quad enable or four-wire mode makes the shared pin data line 3
// - dedicated-pin part ignores bit 7: hold on shared pin while bit 0 is 0, reset once bit 0 is 1
// - read bits 6..3 give dummy cycles 1 to 15
// - dummy field 0 means command default: 8 in SPI, 6 in FOUR_WIRE_COMMAND_MODE
// - read bit 2 enables burst wrap at the length in bits 1..0
// - wrap disabled means wrap only at end of whole array
// - length code 00/01/10/11 gives 8/16/32/64 bytes
// - opcode 65h writes non-volatile copy; C0h or 63h write volatile copy
// - read parameter bits all reset to 0
`ifndef FLASH_CFG_CONSTS_VH
`define FLASH_CFG_CONSTS_VH

// serial opcodes
`define OP_SET_READ_NV      8'h65
`define OP_SET_READ_V0      8'hc0
`define OP_SET_READ_V1      8'h63
`define OP_GET_READ_PARAMS  8'h61
`define OP_SET_FUNCTION     8'h42
`define OP_GET_FUNCTION     8'h48

// function register fields
`define FN_RESET_DIS_BIT    0
`define FN_BOTTOM_BIT       1
`define FN_PROGRAM_SUSPENDED_FLAG_BIT         2
`define FN_ERASE_SUSPENDED_FLAG_BIT         3
`define FN_ROWLOCK_LSB      4
`define FN_OTP_MASK         8'hf3
`define FN_RESET_VALUE      8'h00

// read parameter register fields
`define RP_PIN_SEL_BIT      7
`define RP_DUMMY_MSB        6
`define RP_DUMMY_LSB        3
`define RP_WRAP_EN_BIT      2
`define RP_LEN_MSB          1
`define RP_LEN_LSB          0
`define RP_RESET_VALUE      8'h00

// default dummy counts when the field is zero
`define DUMMY_DEF_SPI       4'h8
`define DUMMY_DEF_QPI       4'h6

// wrap burst lengths in bytes
`define WRAP_LEN_8          7'h08
`define WRAP_LEN_16         7'h10
`define WRAP_LEN_32         7'h20
`define WRAP_LEN_64         7'h40

// shared pin functions
`define PIN_FN_HOLD         2'h0
`define PIN_FN_RESET        2'h1
`define PIN_FN_DATA3        2'h2

`endif

// ### hdl/serial_byte_shifter.v
// byte shifter for a mode-0 serial link: samples on rising edges, shifts out on falling
// assumes edge strobes already derived from a synchronised serial clock
`timescale 1ns/10ps
module serial_byte_shifter (
    // clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // link strobes
    input  wire       sckRise,
    input  wire       sckFall,
    input  wire       csActive,
    input  wire       siBit,
    // reply load
    input  wire       loadByte,
    input  wire [7:0] txByte,
    // results
    output reg  [7:0] rxByte,
    output reg        rxValid,
    output wire       soBit
);
    reg [2:0] bitCount_r;
    reg [6:0] rxShift_r;
    reg [7:0] txShift_r;

    assign soBit = txShift_r[7];

    always @(posedge clock) begin
        if (!rst_n || !csActive) begin
            bitCount_r <= 3'h0;
            rxShift_r  <= 7'h00;
            rxByte     <= 8'h00;
            rxValid    <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (sckRise) begin
                bitCount_r <= bitCount_r + 3'h1;
                rxShift_r  <= {rxShift_r[5:0], siBit};
                if (bitCount_r == 3'h7) begin
                    rxByte  <= {rxShift_r, siBit};
                    rxValid <= 1'b1;
                end
            end
        end
    end

    // the fall right after a byte boundary is skipped so the reply's msb is not lost
    always @(posedge clock) begin
        if (!rst_n || !csActive)
            txShift_r <= 8'h00;
        else if (loadByte)
            txShift_r <= txByte;
        else if (sckFall && bitCount_r != 3'h0)
            txShift_r <= {txShift_r[6:0], 1'b0};
    end
endmodule

// ### bench/host_spi_model.sv
// host controller model: mode 0 frames of one opcode byte and one data byte
// assumes it is clocked by the system clock; sck rests low between frames
`timescale 1ns/10ps
module host_spi_model (
    // clock
    input  wire       clock,
    // serial link
    output reg        sck,
    output reg        csN,
    output reg        si,
    input  wire       so,
    input  wire       soOe
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end
    // the second byte's bits come back in rdv, unknown where so is not driven
    task xfer(input [7:0] op, input [7:0] wd, output [7:0] rdv);
        reg [15:0] sh;
        integer i;
        begin
            sh = {op, wd};
            rdv = 8'h00;
            @(posedge clock);
            csN <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                si <= sh[15 - i];
                repeat (4) @(posedge clock);
                sck <= 1'b1;
                repeat (3) @(posedge clock);
                // so moves some clocks after a falling sck, so sample late in the high phase
                @(negedge clock);
                if (i > 7)
                    rdv = {rdv[6:0], soOe ? so : 1'bx};
                @(posedge clock);
                sck <= 1'b0;
            end
            repeat (4) @(posedge clock);
            csN <= 1'b1;
            si <= ~si;
            repeat (4) @(posedge clock);
        end
    endtask
endmodule

// ### bench/flash_config_registers_monitor.sv
// checker on the config register outputs, bound into the top module
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
`include "flash_cfg_consts.vh"
module flash_config_registers_monitor #(
    parameter HAS_DEDICATED_RESET = 1
) (
    // clock and reset
    input wire       clock,
    input wire       rst_n,
    // mode levels and engine events
    input wire       quadEnable,
    input wire       fourWireCmdMode,
    input wire       programActive,
    input wire       eraseActive,
    input wire       suspendAccepted,
    input wire       programResumed,
    // row requests
    input wire       rowProgReq,
    input wire [1:0] rowSel,
    input wire       rowProgGrant,
    input wire       rowProgReject,
    // resolved configuration
    input wire [1:0] sharedPinFunction,
    input wire [3:0] readDummyCycles,
    input wire       wrapEnable,
    input wire       wrapWholeArray,
    input wire [6:0] wrapBytes,
    input wire [7:0] functionValue,
    input wire [7:0] readParamsVolatile
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // decoded outputs trail the registers, so judge them only after a quiet spell
    sequence s_quiet;
        ($past(rst_n) && $stable(readParamsVolatile) && $stable(functionValue)
            && $stable({quadEnable, fourWireCmdMode}))[*4];
    endsequence
    property p_otp_kept;
        ($past(functionValue) & ~functionValue & `FN_OTP_MASK) == 8'h00;
    endproperty
    a_otp_kept: assert property (p_otp_kept) else $error("one-time bit cleared");
    property p_prog_susp;
        suspendAccepted && programActive |-> ##[1:2] functionValue[2];
    endproperty
    a_prog_susp: assert property (p_prog_susp) else $error("program flag not set");
    property p_prog_resume;
        programResumed && !suspendAccepted |-> ##[1:2] !functionValue[2];
    endproperty
    a_prog_resume: assert property (p_prog_resume) else $error("program flag kept");
    property p_erase_susp;
        suspendAccepted && eraseActive |-> ##[1:2] functionValue[3];
    endproperty
    a_erase_susp: assert property (p_erase_susp) else $error("erase flag not set");
    property p_row_lock;
        rowProgReq |=> rowProgReject == $past(functionValue[{1'b1, rowSel}])
            && rowProgGrant == !rowProgReject;
    endproperty
    a_row_lock: assert property (p_row_lock) else $error("row lock ignored");
    property p_data_line;
        (quadEnable || fourWireCmdMode)[*2] |-> sharedPinFunction == `PIN_FN_DATA3;
    endproperty
    a_data_line: assert property (p_data_line) else $error("shared pin not data");
    property p_pin_fn;
        !quadEnable && !fourWireCmdMode ##0 s_quiet |-> sharedPinFunction == (HAS_DEDICATED_RESET
            ? {1'b0, functionValue[0]} : {1'b0, readParamsVolatile[7]});
    endproperty
    a_pin_fn: assert property (p_pin_fn) else $error("shared pin function");
    property p_dummy;
        s_quiet |-> readDummyCycles == ((readParamsVolatile[6:3] != 4'h0) ? readParamsVolatile[6:3]
            : (fourWireCmdMode ? `DUMMY_DEF_QPI : `DUMMY_DEF_SPI));
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count");
    property p_wrap;
        s_quiet |-> wrapEnable == readParamsVolatile[2] && wrapWholeArray == !readParamsVolatile[2]
            && wrapBytes == (7'h08 << readParamsVolatile[1:0]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap setting");
endmodule
bind flash_config_registers flash_config_registers_monitor #(
    .HAS_DEDICATED_RESET(HAS_DEDICATED_RESET)
) i_monitor (
    .clock, .rst_n, .quadEnable, .fourWireCmdMode, .programActive, .eraseActive,
    .suspendAccepted, .programResumed, .rowProgReq, .rowSel, .rowProgGrant, .rowProgReject,
    .sharedPinFunction, .readDummyCycles, .wrapEnable, .wrapWholeArray, .wrapBytes,
    .functionValue, .readParamsVolatile
);

// ### bench/tb_flash_config_registers.sv
// self-checking bench for the function and read-parameter registers
// host model drives the serial pins; pins, modes and engine events come from here
`timescale 1ns/10ps
`include "flash_cfg_consts.vh"
module tb_flash_config_registers;
    reg        clock = 1'b0, rst_n = 1'b0;
    reg        quadEnable = 1'b0, fourWireCmdMode = 1'b0;
    reg        dedicatedResetPinN = 1'b1, sharedPinN = 1'b1;
    reg        programActive = 1'b0, eraseActive = 1'b0, suspendAccepted = 1'b0;
    reg        programResumed = 1'b0, eraseResumed = 1'b0, rowProgReq = 1'b0;
    reg  [1:0] rowSel = 2'h0;
    reg  [7:0] got;
    wire       sck, csN, si, so, soOe, rowProgGrant, rowProgReject, holdActive;
    wire       deviceResetReq, protectAreaBottom, wrapEnable, wrapWholeArray;
    wire [1:0] sharedPinFunction;
    wire [3:0] readDummyCycles;
    wire [6:0] wrapBytes;
    wire [7:0] functionValue, readParamsVolatile;
    integer    n_fail = 0, checks = 0, cycles = 0, k;
    flash_config_registers #(.HAS_DEDICATED_RESET(1), .RESET_DIS_DEFAULT(1'b0)) i_dut (
        .clock, .rst_n, .sck, .csN, .si, .so, .soOe, .dedicatedResetPinN, .sharedPinN,
        .quadEnable, .fourWireCmdMode, .programActive, .eraseActive, .suspendAccepted,
        .programResumed, .eraseResumed, .rowProgReq, .rowSel, .rowProgGrant, .rowProgReject,
        .sharedPinFunction, .holdActive, .deviceResetReq, .protectAreaBottom,
        .readDummyCycles, .wrapEnable, .wrapWholeArray, .wrapBytes, .functionValue,
        .readParamsVolatile
    );
    host_spi_model i_host (.clock, .sck, .csN, .si, .so, .soOe);
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 12000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        begin
            if (n_fail == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input [7:0] act, input [7:0] exp);
        begin
            checks = checks + 1;
            if (act !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, act, exp);
            end
        end
    endtask
    task do_reset;
        begin
            @(posedge clock);
            rst_n <= 1'b0;
            repeat (4) @(posedge clock);
            rst_n <= 1'b1;
            repeat (4) @(posedge clock);
            @(negedge clock);
        end
    endtask
    task wr(input [7:0] op, input [7:0] d);
        begin
            i_host.xfer(op, d, got);
            repeat (4) @(posedge clock);
            @(negedge clock);
        end
    endtask
    task rd(input [7:0] op, input [7:0] exp);
        begin
            i_host.xfer(op, 8'h00, got);
            check(got, exp);
        end
    endtask
    // v is {quadEnable, fourWireCmdMode, dedicatedResetPinN, sharedPinN}
    task setin(input [3:0] v);
        begin
            @(posedge clock);
            {quadEnable, fourWireCmdMode, dedicatedResetPinN, sharedPinN} <= v;
            repeat (6) @(posedge clock);
            @(negedge clock);
        end
    endtask
    task ev(input [1:0] act, input [2:0] e);
        begin
            @(posedge clock);
            {programActive, eraseActive} <= act;
            {suspendAccepted, programResumed, eraseResumed} <= e;
            @(posedge clock);
            {suspendAccepted, programResumed, eraseResumed} <= 3'h0;
            repeat (2) @(posedge clock);
            @(negedge clock);
        end
    endtask
    task row(input [1:0] sel, input rej);
        begin
            @(posedge clock);
            rowProgReq <= 1'b1;
            rowSel <= sel;
            repeat (2) @(posedge clock);
            @(negedge clock);
            check({rowProgReject, rowProgGrant}, {rej, ~rej});
            @(posedge clock);
            rowProgReq <= 1'b0;
        end
    endtask
    initial begin
        do_reset;
        check(functionValue, 8'h00);
        check({readDummyCycles, wrapEnable, wrapWholeArray}, 8'h21);
        check({1'b0, wrapBytes}, 8'h08);
        rd(`OP_GET_READ_PARAMS, 8'h00);
        wr(`OP_SET_READ_V0, 8'h55);
        rd(`OP_GET_READ_PARAMS, 8'h55);
        check({readDummyCycles, wrapEnable, wrapWholeArray}, 8'h2a);
        for (k = 0; k < 4; k = k + 1) begin
            wr(k[0] ? `OP_SET_READ_V1 : `OP_SET_READ_V0, {5'h1f, 1'b1, k[1:0]});
            check({1'b0, wrapBytes}, 8'h08 << k);
        end
        check({readDummyCycles, sharedPinFunction}, 8'h3c);
        wr(`OP_SET_READ_NV, 8'h00);
        check(readParamsVolatile, 8'hff);
        wr(`OP_SET_READ_V0, 8'h03);
        setin(4'b0111);
        check({readDummyCycles, wrapEnable, wrapWholeArray}, 8'h19);
        check(sharedPinFunction, 8'h02);
        setin(4'b1011);
        check({readDummyCycles, sharedPinFunction}, 8'h22);
        setin(4'b0001);
        check({deviceResetReq, holdActive}, 8'h02);
        setin(4'b0010);
        check({deviceResetReq, holdActive}, 8'h01);
        setin(4'b0011);
        wr(`OP_SET_FUNCTION, 8'h0c);
        rd(`OP_GET_FUNCTION, 8'h00);
        wr(8'h5a, 8'hff);
        rd(`OP_GET_READ_PARAMS, 8'h03);
        wr(`OP_SET_FUNCTION, 8'h12);
        check(protectAreaBottom, 8'h01);
        row(2'h0, 1'b1);
        row(2'h1, 1'b0);
        wr(`OP_SET_FUNCTION, 8'h00);
        rd(`OP_GET_FUNCTION, 8'h12);
        wr(`OP_SET_FUNCTION, 8'he1);
        rd(`OP_GET_FUNCTION, 8'hf3);
        row(2'h3, 1'b1);
        check(sharedPinFunction, 8'h01);
        setin(4'b0001);
        check({deviceResetReq, holdActive}, 8'h00);
        setin(4'b0010);
        check({deviceResetReq, holdActive}, 8'h02);
        setin(4'b0011);
        ev(2'b10, 3'b100);
        check(functionValue, 8'hf7);
        ev(2'b10, 3'b010);
        check(functionValue, 8'hf3);
        ev(2'b01, 3'b100);
        rd(`OP_GET_FUNCTION, 8'hfb);
        ev(2'b01, 3'b001);
        check(functionValue, 8'hf3);
        do_reset;
        check(readParamsVolatile, 8'h00);
        report_and_stop;
    end
endmodule
